/* hw/cmrd_consts.svh */
`ifndef CMRD_CONSTS_SVH
`define CMRD_CONSTS_SVH

// ---------------------------------------------------------------
// Divider geometry
// ---------------------------------------------------------------
`define CMRD_PRE_W        2
`define CMRD_LONG_W       12
`define CMRD_EXT_REFERENCE_TAP     8
`define CMRD_INT_REFERENCE_TAP     5
`define CMRD_MISS_LIMIT   2'h2

// ---------------------------------------------------------------
// Register map (byte addresses)
// ---------------------------------------------------------------
`define CMRD_ADDR_W       12
`define CMRD_ADDR_CTRL    12'h000
`define CMRD_ADDR_STAT    12'h004

// Control register fields.
`define CMRD_CTRL_EXT_ON  0
`define CMRD_CTRL_INT_ON  1
`define CMRD_CTRL_SLOW    2
`define CMRD_CTRL_MON     3

// Status register fields.
`define CMRD_STAT_EXT_STB 0
`define CMRD_STAT_EXT_OFF 1
`define CMRD_STAT_INT_OFF 2
`define CMRD_STAT_MON     3
`define CMRD_STAT_INT_STB 4
`define CMRD_STAT_FAIL    5

// Reset values.
`define CMRD_RST_BIT      1'h0
`define CMRD_RST_WORD     32'h00000000

`endif

/* hw/cmrd_pkg.sv */
package cmrd_pkg;

  // Source that feeds the long divider.
  typedef enum logic {
    CMRD_SRC_EXT,
    CMRD_SRC_BASE
  } cmrd_long_src_t;

endpackage : cmrd_pkg

/* hw/cmrd_sync3.sv */
`timescale 1ns/1ps
`default_nettype none
`include "cmrd_consts.svh"

module cmrd_sync3
  import cmrd_pkg::*;
(
  input  wire logic clk_sys,  // System clock.
  input  wire logic reset_n,  // Asynchronous reset, active low.
  input  wire logic pin_in,   // Asynchronous input.
  output var  logic level,    // Filtered level.
  output var  logic fall      // One-cycle pulse on a falling edge.
);

  logic s1_q;
  logic s2_q;
  logic s3_q;

  // Three stage synchroniser; only the second stage reads the first.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      s1_q <= `CMRD_RST_BIT;
      s2_q <= `CMRD_RST_BIT;
      s3_q <= `CMRD_RST_BIT;
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // A change counts once stages two and three agree.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      level <= `CMRD_RST_BIT;
      fall  <= `CMRD_RST_BIT;
    end else begin
      fall <= (s2_q == s3_q) && level && !s3_q;
      if (s2_q == s3_q) begin
        level <= s3_q;
      end
    end
  end

endmodule : cmrd_sync3

`default_nettype wire

/* hw/cmrd_div.sv */
`timescale 1ns/1ps
`default_nettype none

module cmrd_div
  import cmrd_pkg::*;
#(
  parameter int W = 2
) (
  input  wire logic         clk_sys,  // System clock.
  input  wire logic         reset_n,  // Asynchronous reset, active low.
  input  wire logic         clr,      // Synchronous hold at zero.
  input  wire logic         tick,     // Source clock falling edge.
  output var  logic [W-1:0] cnt       // Binary count; bit k is source / 2^(k+1).
);

  // Counter advancing once per source edge, held at zero when cleared.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      cnt <= '0;
    end else if (clr) begin
      cnt <= '0;
    end else if (tick) begin
      cnt <= cnt + {{(W-1){1'b0}}, 1'b1};
    end
  end

endmodule : cmrd_div

`default_nettype wire

/* hw/cmrd_top.sv */
// Behaviour
// RULE1 - Slow crystal bit selects reduced amplifier gain.
// RULE2 - Amplifier on only if external on, no stop.
// RULE3 - Input path on only if external on, no stop.
// RULE4 - Enabled monitor flags failure of either clock.
// RULE5 - Monitor enable needs both on and both stable.
// RULE6 - Monitor stays enabled after a stable flag drops.
// RULE7 - References come from external and base clocks.
// RULE8 - Both clocks always pass a divide-by-four; the long divider here counts undivided source edges.
// RULE9 - Long divider doubles as stabilisation timer.
// RULE10 - Unstable: long divider counts external clock.
// RULE11 - Stabilisation clock falling edge sets stable flag.
// RULE12 - Later stabilisation edges never clear stable flag.
// RULE13 - Stable cleared by inactivity reverts long divider.
// RULE14 - Software clears monitor enable after inactivity.
// RULE15 - Disabled generators hold their references low.
// RULE16 - Fast crystal: ext/512, base/4, ext/4096.
// RULE17 - Slow crystal: ext/4, base/64, base/4096.
// RULE18 - Software matches slow bit to crystal range.
// RULE19 - Stable flag clears on external off or inactivity.
// RULE20 - Two missed reference low phases flag inactivity.
// RULE21 - Dividers count their source, held when disabled.

`timescale 1ns/1ps
`default_nettype none
`include "cmrd_consts.svh"

module cmrd_top
  import cmrd_pkg::*;
#(
  parameter int LONG_W   = `CMRD_LONG_W,
  parameter int PRE_W    = `CMRD_PRE_W,
  parameter int EXT_REFERENCE_TAP = `CMRD_EXT_REFERENCE_TAP,
  parameter int INT_REFERENCE_TAP = `CMRD_INT_REFERENCE_TAP
) (
  input  wire logic                    clk_sys,             // System clock, 20 MHz.
  input  wire logic                    reset_n,             // Asynchronous reset.
  input  wire logic                    psel,                // APB select.
  input  wire logic                    penable,             // APB enable.
  input  wire logic                    pwrite,              // APB direction.
  input  wire logic [`CMRD_ADDR_W-1:0] paddr,               // APB byte address.
  input  wire logic [31:0]             pwdata,              // APB write data.
  output var  logic [31:0]             prdata,              // APB read data.
  output var  logic                    pready,              // APB ready.
  output var  logic                    pslverr,             // APB error.
  input  wire logic                    osc_input_pin,       // Oscillator input pin.
  input  wire logic                    base_clock,          // Base clock in.
  input  wire logic                    stop_mode,           // Stop mode active.
  input  wire logic                    int_stable_flag,     // Internal clock stable.
  output var  logic                    amp_enable,          // Amplifier enable.
  output var  logic                    amp_slow_gain,       // Reduced amplifier gain.
  output var  logic                    input_path_enable,   // Input buffer enable.
  output var  logic                    external_clock,      // Gated external clock.
  output var  logic                    ext_reference,       // External reference.
  output var  logic                    int_reference,       // Internal reference.
  output var  logic                    stabilization_clock, // Stabilisation clock.
  output var  logic                    ext_stable_flag,     // External clock stable.
  output var  logic                    ext_inactive_flag,   // External inactive.
  output var  logic                    int_inactive_flag,   // Base clock inactive.
  output var  logic                    monitor_enable,      // Monitor enabled.
  output var  logic                    clock_fail           // Source failure seen.
);

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  logic              ext_gen_on_q;
  logic              int_gen_on_q;
  logic              slow_q;
  logic              monitor_q;
  logic              ext_stable_q;
  logic              amp_enable_q;
  logic              amp_slow_q;
  logic              path_enable_q;
  logic              ext_clock_q;
  logic              ext_reference_q;
  logic              int_reference_q;
  logic              estb_q;
  logic              fail_q;
  logic [31:0]       prdata_q;
  logic              pready_q;
  logic              pslverr_q;
  logic              ext_gen_enable;
  logic              int_gen_enable;
  logic              ext_level;
  logic              ext_fall_raw;
  logic              base_level;
  logic              base_fall_raw;
  logic              ext_fall;
  logic              base_fall;
  logic [PRE_W-1:0]  ext_pre_cnt;
  logic [PRE_W-1:0]  base_pre_cnt;
  logic [LONG_W-1:0] long_cnt;
  cmrd_long_src_t    long_src;
  logic              long_tick;
  logic              ext_reference_d;
  logic              int_reference_d;
  logic              estb_d;
  logic              estb_fall;
  logic              mon_allowed;
  logic              access;
  logic              done;
  logic              hit_ctrl;
  logic              hit_stat;
  logic [31:0]       ctrl_word;
  logic [31:0]       stat_word;
  logic [1:0]        ref_w;
  logic [1:0]        ref_prev_q;
  logic [1:0]        fall_w;
  logic [1:0]        seen_q;
  logic [1:0]        miss_q [2];
  logic [1:0]        off_q;

  // ---------------------------------------------------------------
  // Generator enables
  // ---------------------------------------------------------------
  // Stop mode gates both generators off.
  assign ext_gen_enable = ext_gen_on_q & ~stop_mode;  // see RULE2
  assign int_gen_enable = int_gen_on_q & ~stop_mode;

  // Amplifier and input path controls.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      amp_enable_q  <= `CMRD_RST_BIT;
      amp_slow_q    <= `CMRD_RST_BIT;
      path_enable_q <= `CMRD_RST_BIT;
    end else begin
      amp_enable_q  <= ext_gen_enable;  // see RULE2
      amp_slow_q    <= slow_q;          // see RULE1
      path_enable_q <= ext_gen_enable;  // see RULE3
    end
  end

  // ---------------------------------------------------------------
  // Clock inputs
  // ---------------------------------------------------------------
  cmrd_sync3 u_ext_sync (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .pin_in  (osc_input_pin),
    .level   (ext_level),
    .fall    (ext_fall_raw)
  );

  cmrd_sync3 u_base_sync (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .pin_in  (base_clock),
    .level   (base_level),
    .fall    (base_fall_raw)
  );

  // Edges of a disabled source are dropped at the input path.
  assign ext_fall  = ext_fall_raw & ext_gen_enable;  // see RULE3
  assign base_fall = base_fall_raw & int_gen_enable;

  // Gated copy of the external clock for the rest of the chip.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ext_clock_q <= `CMRD_RST_BIT;
    end else begin
      ext_clock_q <= ext_level & ext_gen_enable;  // see RULE3
    end
  end

  // ---------------------------------------------------------------
  // Divide-by-four stages
  // ---------------------------------------------------------------
  // Each source feeds its own quarter divider; the long divider takes the undivided edges.
  cmrd_div #(.W(PRE_W)) u_ext_pre (  // see RULE8
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .clr     (~ext_gen_enable),  // see RULE21
    .tick    (ext_fall),
    .cnt     (ext_pre_cnt)
  );

  cmrd_div #(.W(PRE_W)) u_base_pre (  // see RULE8
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .clr     (~int_gen_enable),  // see RULE21
    .tick    (base_fall),
    .cnt     (base_pre_cnt)
  );

  // ---------------------------------------------------------------
  // Long divider
  // ---------------------------------------------------------------
  // Until stable, or with a fast crystal, the external clock feeds it.
  always_comb begin
    if (!ext_stable_q || !slow_q) begin
      long_src = CMRD_SRC_EXT;  // see RULE10, RULE13, RULE16
    end else begin
      long_src = CMRD_SRC_BASE;  // see RULE17
    end
  end

  assign long_tick = (long_src == CMRD_SRC_EXT) ? ext_fall : base_fall;

  // Held at zero while the external generator is disabled.
  cmrd_div #(.W(LONG_W)) u_long (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .clr     (~ext_gen_enable),  // see RULE9, RULE21
    .tick    (long_tick),
    .cnt     (long_cnt)
  );

  // ---------------------------------------------------------------
  // Reference selection
  // ---------------------------------------------------------------
  // External reference follows the crystal range once stable.
  always_comb begin
    if (!ext_gen_enable || !ext_stable_q) begin
      ext_reference_d = 1'b0;  // see RULE15
    end else if (slow_q) begin
      ext_reference_d = ext_pre_cnt[PRE_W-1];  // see RULE17, RULE7
    end else begin
      ext_reference_d = long_cnt[EXT_REFERENCE_TAP];  // see RULE16, RULE7
    end
  end

  // Internal reference is taken from the base clock, never the fast clock.
  always_comb begin
    if (!int_gen_enable) begin
      int_reference_d = 1'b0;  // see RULE15
    end else if (ext_stable_q && slow_q) begin
      int_reference_d = long_cnt[INT_REFERENCE_TAP];  // see RULE17, RULE7
    end else begin
      int_reference_d = base_pre_cnt[PRE_W-1];  // see RULE16, RULE7
    end
  end

  // Stabilisation clock is the top bit of the long divider.
  assign estb_d = ext_gen_enable & long_cnt[LONG_W-1];  // see RULE9, RULE15

  // A falling edge of the stabilisation clock.
  assign estb_fall = estb_q & ~estb_d & ext_gen_enable;  // see RULE11

  // Registered reference outputs.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ext_reference_q <= `CMRD_RST_BIT;
      int_reference_q <= `CMRD_RST_BIT;
      estb_q <= `CMRD_RST_BIT;
    end else begin
      ext_reference_q <= ext_reference_d;
      int_reference_q <= int_reference_d;
      estb_q <= estb_d;
    end
  end

  // ---------------------------------------------------------------
  // External stable flag
  // ---------------------------------------------------------------
  // The stabilisation edge only ever sets; it wins over a clear.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ext_stable_q <= `CMRD_RST_BIT;
    end else if (estb_fall) begin
      ext_stable_q <= 1'b1;  // see RULE11, RULE12
    end else if (!ext_gen_on_q || off_q[0]) begin
      ext_stable_q <= 1'b0;  // see RULE19, RULE13
    end
  end

  // ---------------------------------------------------------------
  // Activity detectors
  // ---------------------------------------------------------------
  // Slot 0 watches the external clock against the internal reference,
  // slot 1 watches the base clock against the external reference.
  assign ref_w  = {ext_reference_q, int_reference_q};
  assign fall_w = {base_fall, ext_fall};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_det
      // Counts reference low phases that pass without a source edge.
      always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
          ref_prev_q[gi] <= `CMRD_RST_BIT;
          seen_q[gi]     <= `CMRD_RST_BIT;
          miss_q[gi]     <= 2'h0;
          off_q[gi]      <= `CMRD_RST_BIT;
        end else begin
          ref_prev_q[gi] <= ref_w[gi];
          if (fall_w[gi] && !ref_w[gi]) begin
            seen_q[gi] <= 1'b1;
            miss_q[gi] <= 2'h0;
            off_q[gi]  <= 1'b0;  // see RULE20
          end else if (ref_w[gi] && !ref_prev_q[gi]) begin
            seen_q[gi] <= 1'b0;
            if (!seen_q[gi] && miss_q[gi] != `CMRD_MISS_LIMIT) begin
              miss_q[gi] <= miss_q[gi] + 2'h1;
            end
            if (!seen_q[gi] && miss_q[gi] == `CMRD_MISS_LIMIT - 2'h1) begin
              off_q[gi] <= 1'b1;  // see RULE20
            end
          end
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // Clock monitor
  // ---------------------------------------------------------------
  // Enable is accepted only with both generators on and stable.
  assign mon_allowed = ext_gen_on_q & int_gen_on_q & ext_stable_q & int_stable_flag;

  // A write of zero clears; a refused write of one is ignored.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      monitor_q <= `CMRD_RST_BIT;
    end else if (done && hit_ctrl && pwrite) begin
      if (!pwdata[`CMRD_CTRL_MON]) begin
        monitor_q <= 1'b0;  // see RULE14
      end else if (mon_allowed) begin
        monitor_q <= 1'b1;  // see RULE5
      end
    end
  end

  // Failure is an inactive source while the monitor is on; the
  // monitor itself does not drop when a stable flag falls.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      fail_q <= `CMRD_RST_BIT;
    end else begin
      fail_q <= monitor_q & (off_q[0] | off_q[1]);  // see RULE4, RULE6
    end
  end

  // ---------------------------------------------------------------
  // APB slave
  // ---------------------------------------------------------------
  assign access   = psel & penable;
  assign done     = access & pready_q;
  assign hit_ctrl = (paddr == `CMRD_ADDR_CTRL);
  assign hit_stat = (paddr == `CMRD_ADDR_STAT);

  // Control word as read back.
  always_comb begin
    ctrl_word                   = `CMRD_RST_WORD;
    ctrl_word[`CMRD_CTRL_EXT_ON] = ext_gen_on_q;
    ctrl_word[`CMRD_CTRL_INT_ON] = int_gen_on_q;
    ctrl_word[`CMRD_CTRL_SLOW]   = slow_q;
    ctrl_word[`CMRD_CTRL_MON]    = monitor_q;
  end

  // Status word showing live block state.
  always_comb begin
    stat_word                    = `CMRD_RST_WORD;
    stat_word[`CMRD_STAT_EXT_STB] = ext_stable_q;
    stat_word[`CMRD_STAT_EXT_OFF] = off_q[0];
    stat_word[`CMRD_STAT_INT_OFF] = off_q[1];
    stat_word[`CMRD_STAT_MON]     = monitor_q;
    stat_word[`CMRD_STAT_INT_STB] = int_stable_flag;
    stat_word[`CMRD_STAT_FAIL]    = fail_q;
  end

  // One wait state: the answer is registered in the first access cycle.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pready_q  <= `CMRD_RST_BIT;
      pslverr_q <= `CMRD_RST_BIT;
      prdata_q  <= `CMRD_RST_WORD;
    end else begin
      pready_q  <= access & ~pready_q;
      pslverr_q <= access & ~pready_q & ~hit_ctrl & ~hit_stat;
      if (access && !pready_q && !pwrite) begin
        prdata_q <= hit_ctrl ? ctrl_word : (hit_stat ? stat_word : `CMRD_RST_WORD);
      end else if (!access) begin
        prdata_q <= `CMRD_RST_WORD;
      end
    end
  end

  // Control bits take a write at the completing edge.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ext_gen_on_q <= `CMRD_RST_BIT;
      int_gen_on_q <= `CMRD_RST_BIT;
      slow_q       <= `CMRD_RST_BIT;
    end else if (done && hit_ctrl && pwrite) begin
      ext_gen_on_q <= pwdata[`CMRD_CTRL_EXT_ON];
      int_gen_on_q <= pwdata[`CMRD_CTRL_INT_ON];
      slow_q       <= pwdata[`CMRD_CTRL_SLOW];  // see RULE18
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  // Every output is a flip-flop.
  assign prdata              = prdata_q;
  assign pready              = pready_q;
  assign pslverr             = pslverr_q;
  assign amp_enable          = amp_enable_q;
  assign amp_slow_gain       = amp_slow_q;
  assign input_path_enable   = path_enable_q;
  assign external_clock      = ext_clock_q;
  assign ext_reference       = ext_reference_q;
  assign int_reference       = int_reference_q;
  assign stabilization_clock = estb_q;
  assign ext_stable_flag     = ext_stable_q;
  assign ext_inactive_flag   = off_q[0];
  assign int_inactive_flag   = off_q[1];
  assign monitor_enable      = monitor_q;
  assign clock_fail          = fail_q;

endmodule : cmrd_top

`default_nettype wire

/* verification/cmrd_checker.sv */
`timescale 1ns/1ps
`default_nettype none
// --------------------------------------------------------------
// Port checker
// --------------------------------------------------------------
module cmrd_checker (
  input wire logic clk_sys,             // Clock.
  input wire logic reset_n,             // Reset.
  input wire logic psel,                // APB select.
  input wire logic pready,              // APB ready.
  input wire logic stop_mode,           // Stop mode.
  input wire logic int_stable_flag,     // Internal stable.
  input wire logic amp_enable,          // Amplifier on.
  input wire logic input_path_enable,   // Input path on.
  input wire logic external_clock,      // Gated clock.
  input wire logic ext_reference,       // External reference.
  input wire logic stabilization_clock, // Stabilisation clock.
  input wire logic ext_stable_flag,     // External stable.
  input wire logic ext_inactive_flag,   // External inactive.
  input wire logic monitor_enable,      // Monitor on.
  input wire logic clock_fail           // Failure seen.
);
  // Checks rest during reset.
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);
  a_amp_no_stop: assert property (amp_enable |-> !$past(stop_mode))
    else $error("amplifier on during stop mode");
  a_path_amp_same: assert property (input_path_enable == amp_enable)
    else $error("input path differs from amplifier enable");
  a_ext_clk_gated: assert property (!input_path_enable [*3] |-> !external_clock)
    else $error("external clock passes while path is off");
  a_fail_on_loss: assert property (monitor_enable && ext_inactive_flag |=> clock_fail)
    else $error("failure not flagged");
  a_mon_needs_stable: assert property ($rose(monitor_enable) |->
    $past(ext_stable_flag) && $past(int_stable_flag))
    else $error("monitor enabled without stable clocks");
  a_mon_stays_on: assert property ($past(monitor_enable) && !$past(psel) |-> monitor_enable)
    else $error("monitor dropped without a write");
  a_ext_reference_unstable: assert property (!ext_stable_flag && !$past(ext_stable_flag) |->
    !ext_reference)
    else $error("external reference runs while unstable");
  a_estb_off: assert property (!input_path_enable [*3] |-> !stabilization_clock)
    else $error("stabilisation clock runs while disabled");
  a_stable_on_fall: assert property ($fell(stabilization_clock) |->
    ##[1:2] (ext_stable_flag || !input_path_enable))
    else $error("stable flag not set by stabilisation edge");
  a_stable_clears: assert property ($rose(ext_inactive_flag) |-> ##[0:2] !ext_stable_flag)
    else $error("stable flag kept after inactivity");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  c_stable: cover property ($rose(ext_stable_flag));
  c_fail: cover property ($rose(clock_fail));
  c_mon: cover property ($rose(monitor_enable));
endmodule : cmrd_checker

bind cmrd_top cmrd_checker chk_u (.*);
`default_nettype wire

/* verification/test_clock_monitor_reference_divider.sv */
`timescale 1ns/1ps
`default_nettype none
// --------------------------------------------------------------
// Bench top
// --------------------------------------------------------------
module test_clock_monitor_reference_divider;
  localparam int EP = 8;
  localparam int BP = 10;
  localparam int LW = 6;
  localparam int ET = 3;
  localparam int IT = 2;
  logic        clk_sys = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000, prdata;
  logic        pready, pslverr, osc_input_pin = 1'b0, base_clock = 1'b0, stop_mode = 1'b0;
  logic        int_stable_flag = 1'b0, ext_run = 1'b1, amp_enable, amp_slow_gain;
  logic        input_path_enable, external_clock, ext_reference, int_reference;
  logic        stabilization_clock, ext_stable_flag, ext_inactive_flag, int_inactive_flag;
  logic        monitor_enable, clock_fail;
  int          ecnt = 0, bcnt = 0, num_errors = 0, total_checks = 0;

  cmrd_top #(.LONG_W(LW), .PRE_W(2), .EXT_REFERENCE_TAP(ET), .INT_REFERENCE_TAP(IT)) dut_u (.*);

  // System clock.
  always #25 clk_sys = ~clk_sys;

  // Pin clocks.
  always @(posedge clk_sys) begin
    ecnt <= (ecnt == EP / 2 - 1) ? 0 : ecnt + 1;
    bcnt <= (bcnt == BP / 2 - 1) ? 0 : bcnt + 1;
    if (ext_run && ecnt == EP / 2 - 1) osc_input_pin <= ~osc_input_pin;
    if (bcnt == BP / 2 - 1) base_clock <= ~base_clock;
  end

  task automatic wrap_up();
    if (num_errors == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %0h seen %0h", nm, exp, got);
    end
  endtask : chk

  // One bounded APB transfer.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      num_errors++;
      wrap_up();
    end
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic eexp);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h00000000, r, e);
    chk("prdata", exp, r);
    chk("pslverr", {31'h0, eexp}, {31'h0, e});
  endtask : rd

  function automatic logic sig(input int w);
    case (w)
      0: return ext_stable_flag;
      1: return ext_inactive_flag;
      2: return ext_reference;
      3: return int_reference;
      default: return stabilization_clock;
    endcase
  endfunction : sig

  task automatic waitv(input int w, input logic v, input int lim, output int n);
    n = 0;
    while (sig(w) !== v && n < lim) begin
      @(posedge clk_sys);
      n++;
    end
    if (n >= lim) begin
      num_errors++;
      wrap_up();
    end
  endtask : waitv

  task automatic settle(input int k);
    repeat (k) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask : settle

  // Measures one full period in system cycles.
  task automatic period(input int w, input int exp);
    int a, b;
    waitv(w, 1'b0, 2000, a);
    waitv(w, 1'b1, 2000, a);
    waitv(w, 1'b0, 2000, a);
    waitv(w, 1'b1, 2000, b);
    chk("period", exp, a + b);
  endtask : period

  task automatic t_regs();
    rd(12'h000, 32'h00000000, 1'b0);
    rd(12'h004, 32'h00000000, 1'b0);
    rd(12'h008, 32'h00000000, 1'b1);
    wr(12'h000, 32'h00000008);
    rd(12'h000, 32'h00000000, 1'b0);
  endtask : t_regs

  task automatic t_enable();
    int n;
    wr(12'h000, 32'h00000003);
    waitv(0, 1'b1, 1500, n);
    chk("stable_time", 1, n >= (EP << LW) - 2 * EP && n <= (EP << LW) + 4 * EP);
    settle(1);
    chk("amp_enable", 1, amp_enable);
    chk("input_path_enable", 1, input_path_enable);
    chk("amp_slow_gain", 0, amp_slow_gain);
    @(posedge clk_sys);
    stop_mode <= 1'b1;
    settle(1);
    chk("amp_enable", 0, amp_enable);
    chk("input_path_enable", 0, input_path_enable);
    @(posedge clk_sys);
    stop_mode <= 1'b0;
    settle(2);
    chk("amp_enable", 1, amp_enable);
  endtask : t_enable

  task automatic t_ratios();
    period(2, EP << (ET + 1));
    period(3, BP * 4);
    period(4, EP << LW);
    wr(12'h000, 32'h00000007);
    settle(1);
    chk("amp_slow_gain", 1, amp_slow_gain);
    period(2, EP * 4);
    period(3, BP << (IT + 1));
    period(4, BP << LW);
  endtask : t_ratios

  task automatic t_monitor();
    int n;
    wr(12'h000, 32'h00000003);
    wr(12'h000, 32'h0000000B);
    rd(12'h000, 32'h00000003, 1'b0);
    @(posedge clk_sys);
    int_stable_flag <= 1'b1;
    wr(12'h000, 32'h0000000B);
    rd(12'h000, 32'h0000000B, 1'b0);
    ext_run <= 1'b0;
    waitv(1, 1'b1, 400, n);
    settle(3);
    chk("clock_fail", 1, clock_fail);
    chk("monitor_enable", 1, monitor_enable);
    chk("ext_stable_flag", 0, ext_stable_flag);
    rd(12'h004, 32'h0000003A, 1'b0);
    wr(12'h000, 32'h00000003);
    rd(12'h000, 32'h00000003, 1'b0);
    ext_run <= 1'b1;
    waitv(0, 1'b1, 1500, n);
    chk("ext_inactive_flag", 0, ext_inactive_flag);
  endtask : t_monitor

  task automatic t_off();
    int h;
    wr(12'h000, 32'h00000001);
    settle(3);
    h = 0;
    repeat (100) begin
      @(posedge clk_sys);
      if (int_reference !== 1'b0) h++;
    end
    chk("int_reference_high", 0, h);
    wr(12'h000, 32'h00000000);
    settle(3);
    chk("ext_stable_flag", 0, ext_stable_flag);
    chk("ext_reference", 0, ext_reference);
    chk("stabilization_clock", 0, stabilization_clock);
    chk("external_clock", 0, external_clock);
  endtask : t_off

  // Main sequence.
  initial begin
    repeat (8) @(posedge clk_sys);
    reset_n <= 1'b1;
    t_regs();
    t_enable();
    t_ratios();
    t_monitor();
    t_off();
    wrap_up();
  end
endmodule : test_clock_monitor_reference_divider
`default_nettype wire
